/* File: src/pts_pkg.sv */
package pts_pkg;
    localparam int          NUM_CH         = 4;
    localparam int          SLOT_BITS      = 8;
    localparam int          SLOT_W         = 8;
    localparam int          BITCNT_W       = 11;
    localparam int          MAX_SLOTS      = 256;
    localparam int          MAX_BIT_RATE_K = 16384;
    localparam int          FRAME_RATE_K   = 8;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [10:0] BITCNT_RST     = 11'h000;
    localparam logic [10:0] BITCNT_IDLE    = 11'h7ff;
    localparam logic [7:0]  SAMPLE_RST     = 8'h00;
    localparam logic        LAW_MU         = 1'b0;
    localparam logic        LAW_A          = 1'b1;
    localparam logic [7:0]  A_LAW_INVERT   = 8'h55;
    localparam logic [7:0]  IDLE_MU        = 8'hff;
    localparam logic [7:0]  IDLE_A         = 8'hd5;
endpackage

/* File: src/pts_sync2.sv */
`timescale 1ns/1ps
module pts_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule

/* File: src/pts_slot_if.sv */
`timescale 1ns/1ps
// Operation
// - Each channel has its own transmit slot and receive slot, any slot.
// - Bit clock up to 16.384 Mbit/s, up to 256 slots per frame.
// - Slower bit clocks work; fewer slots fit in the frame.
// - Transmit data and receive data use separate pins.
// - Frame strobe starts the frame for all four channels.
// - Eight bit clocks per slot; send and capture bytes in programmed slots.
// - Mu-law or A-law companding is selectable.
// - Transmit pin released outside this device's own slots.
// - Link timing derived from the bit clock input.
module pts_slot_if
    import pts_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_bit_clk,
    input  wire logic                 i_frame_strobe_in,
    input  wire logic                 i_pcm_rx_data_in,
    output logic                      o_pcm_tx_data_out,
    output logic                      o_pcm_tx_data_oe,
    input  wire logic                 i_a_law,
    input  wire logic [NUM_CH*8-1:0]  i_tx_slot,
    input  wire logic [NUM_CH*8-1:0]  i_rx_slot,
    input  wire logic [NUM_CH*8-1:0]  i_tx_sample,
    output logic      [NUM_CH*8-1:0]  o_rx_sample,
    output logic      [NUM_CH-1:0]    o_rx_valid
);
    import pts_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Link domain state
    typedef struct packed {
        logic                  run;
        logic [BITCNT_W-1:0]   bit_cnt;
        logic                  fs_prev;
        logic                  tx_bit;
        logic                  tx_oe;
        logic [NUM_CH*8-1:0]   tx_shadow;
        logic [7:0]            rx_shift;
        logic [NUM_CH*8-1:0]   rx_hold;
        logic [NUM_CH-1:0]     rx_tog;
        logic                  law;
    } pts_link_s;

    pts_link_s lnk_q;
    pts_link_s lnk_d;

    ////////////////////////////////////////////////////////////////////////
    // Core domain state
    typedef struct packed {
        logic [NUM_CH*8-1:0] tx_hold;
        logic [NUM_CH*8-1:0] rx_out;
        logic [NUM_CH-1:0]   rx_tog_seen;
        logic [NUM_CH-1:0]   rx_valid;
    } pts_core_s;

    pts_core_s           core_q;
    pts_core_s           core_d;
    logic [NUM_CH*8-1:0] tx_hold_q;
    logic [NUM_CH-1:0]   rx_tog_sync;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions
    // A-law inverts the even bits, mu-law passes the byte unchanged
    function automatic logic [7:0] pts_compand_xor(input logic law, input logic [7:0] b);
        pts_compand_xor = (law == LAW_A) ? (b ^ A_LAW_INVERT) : b;
    endfunction

    function automatic logic [7:0] pts_field(input logic [NUM_CH*8-1:0] v, input int ch);
        pts_field = v[ch*8 +: 8];
    endfunction

    // Channels whose programmed slot equals the given slot
    function automatic logic [NUM_CH-1:0] pts_slot_hits(input logic [NUM_CH*8-1:0] slots,
                                                        input logic [7:0]          slot);
        logic [NUM_CH-1:0] hits;
        hits = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            hits[c] = (pts_field(slots, c) == slot);
        end
        pts_slot_hits = hits;
    endfunction

    // Byte of the highest matching channel; a shared slot goes to it
    function automatic logic [7:0] pts_pick(input logic [NUM_CH-1:0]   hits,
                                            input logic [NUM_CH*8-1:0] bytes);
        logic [7:0] pick;
        pick = SAMPLE_RST;
        for (int c = 0; c < NUM_CH; c++) begin
            if (hits[c]) begin
                pick = pts_field(bytes, c);
            end
        end
        pts_pick = pick;
    endfunction

    // Lanes named in hits take their new value, the others keep theirs
    function automatic logic [NUM_CH*8-1:0] pts_merge(input logic [NUM_CH*8-1:0] old_v,
                                                      input logic [NUM_CH-1:0]   hits,
                                                      input logic [NUM_CH*8-1:0] new_v);
        logic [NUM_CH*8-1:0] merged;
        merged = old_v;
        for (int c = 0; c < NUM_CH; c++) begin
            if (hits[c]) begin
                merged[c*8 +: 8] = new_v[c*8 +: 8];
            end
        end
        pts_merge = merged;
    endfunction

    // Serial bits go out MSB first
    function automatic logic pts_bit_of(input logic [7:0] b, input logic [2:0] idx);
        pts_bit_of = b[BIT_LAST - idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain next state
    logic              fs_rise;
    logic              run_nxt;
    logic [2:0]        bit_nxt;
    logic [7:0]        slot_nxt;
    logic [7:0]        tx_pick;
    logic [7:0]        tx_byte;
    logic [7:0]        rx_byte;
    logic [7:0]        rx_code;
    logic [NUM_CH-1:0] tx_hits;
    logic [NUM_CH-1:0] rx_hits;

    always_comb begin
        lnk_d         = lnk_q;
        fs_rise       = i_frame_strobe_in & ~lnk_q.fs_prev;
        rx_byte       = {lnk_q.rx_shift[6:0], i_pcm_rx_data_in};
        lnk_d.fs_prev = i_frame_strobe_in;
        // Strobe restarts the count; the run flag drops after the last bit of slot 255
        if (fs_rise) begin
            lnk_d.bit_cnt = BITCNT_RST;
            lnk_d.run     = 1'b1;
        end else if (lnk_q.bit_cnt != BITCNT_IDLE) begin
            lnk_d.bit_cnt = lnk_q.bit_cnt + 11'h001;
        end else begin
            lnk_d.run     = 1'b0;
        end
        // Everything below refers to the bit period that this edge opens
        run_nxt  = lnk_d.run;
        bit_nxt  = lnk_d.bit_cnt[2:0];
        slot_nxt = lnk_d.bit_cnt[10:3];
        tx_hits  = '0;
        rx_hits  = '0;
        if (run_nxt) begin
            tx_hits = pts_slot_hits(i_tx_slot, slot_nxt);
            rx_hits = pts_slot_hits(i_rx_slot, slot_nxt);
        end
        // Receive: shift every bit, capture with the sample of the slot's last bit
        lnk_d.rx_shift = rx_byte;
        rx_code        = pts_compand_xor(lnk_q.law, rx_byte);
        if (bit_nxt == BIT_LAST) begin
            lnk_d.rx_hold = pts_merge(lnk_q.rx_hold, rx_hits, {NUM_CH{rx_code}});
            lnk_d.rx_tog  = lnk_q.rx_tog ^ rx_hits;
        end
        // Transmit: sample and law stay frozen for the whole frame
        if (fs_rise) begin
            lnk_d.law       = i_a_law;
            lnk_d.tx_shadow = tx_hold_q;
        end
        // Enable and data change together at the bit clock edge
        tx_pick      = pts_pick(tx_hits, lnk_d.tx_shadow);
        tx_byte      = pts_compand_xor(lnk_d.law, tx_pick);
        lnk_d.tx_oe  = |tx_hits;
        lnk_d.tx_bit = lnk_d.tx_oe & pts_bit_of(tx_byte, bit_nxt);
    end

    // Link logic runs on the bit clock itself
    always_ff @(posedge i_bit_clk or posedge i_rst) begin
        if (i_rst) begin
            // Idle counter: nothing is driven before the first strobe
            lnk_q         <= '0;
            lnk_q.bit_cnt <= BITCNT_IDLE;
        end else begin
            lnk_q <= lnk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain logic
    // Samples must hold steady around the frame strobe; this path has no handshake
    assign tx_hold_q = core_q.tx_hold;

    pts_sync2 #(.W(NUM_CH)) u_tog_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (lnk_q.rx_tog),
        .o_q   (rx_tog_sync)
    );

    always_comb begin
        core_d             = core_q;
        core_d.tx_hold     = i_tx_sample;
        core_d.rx_tog_seen = rx_tog_sync;
        // A lane updates, and pulses valid, in the cycle its toggle is first seen
        core_d.rx_valid    = rx_tog_sync ^ core_q.rx_tog_seen;
        core_d.rx_out      = pts_merge(core_q.rx_out, core_d.rx_valid, lnk_q.rx_hold);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            core_q <= '0;
        end else begin
            core_q <= core_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_pcm_tx_data_out = lnk_q.tx_bit;
    assign o_pcm_tx_data_oe  = lnk_q.tx_oe;
    assign o_rx_sample       = core_q.rx_out;
    assign o_rx_valid        = core_q.rx_valid;
endmodule

/* File: test/pts_slot_if_properties.sv */
`timescale 1ns/1ps
module pts_chk
    import pts_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_bit_clk,
    input wire logic        i_frame_strobe_in,
    input wire logic        o_pcm_tx_data_oe,
    input wire logic [31:0] i_tx_slot,
    input wire logic [31:0] o_rx_sample,
    input wire logic [3:0]  o_rx_valid
);
    logic        fs_q;
    logic        run_q;
    logic        hit;
    logic [10:0] cnt_q;
    // Own bit count; run covers slots 0 to 255 after a strobe
    always_ff @(posedge i_bit_clk or posedge i_rst) begin
        if (i_rst) begin
            fs_q  <= 1'b0;
            run_q <= 1'b0;
            cnt_q <= 11'h7ff;
        end else begin
            fs_q  <= i_frame_strobe_in;
            if (i_frame_strobe_in && !fs_q) begin
                cnt_q <= 11'h000;
                run_q <= 1'b1;
            end else if (cnt_q != 11'h7ff) begin
                cnt_q <= cnt_q + 11'h001;
            end else begin
                run_q <= 1'b0;
            end
        end
    end
    always_comb begin
        hit = 1'b0;
        for (int c = 0; c < NUM_CH; c++)
            hit |= run_q && i_tx_slot[c*8+:8] == cnt_q[10:3];
    end
    oe_slot_a: assert property (@(posedge i_bit_clk) disable iff (i_rst)
        o_pcm_tx_data_oe == hit) else $error("tx enable off slot");
    oe_start_a: assert property (@(posedge i_bit_clk) disable iff (i_rst)
        $rose(o_pcm_tx_data_oe) |-> cnt_q[2:0] == 3'h0) else $error("tx enable late");
    oe_stop_a: assert property (@(posedge i_bit_clk) disable iff (i_rst)
        $fell(o_pcm_tx_data_oe) |-> cnt_q[2:0] == 3'h0) else $error("tx release off edge");
    oe_run_a: assert property (@(posedge i_bit_clk) disable iff (i_rst)
        $rose(o_pcm_tx_data_oe) |-> o_pcm_tx_data_oe [*8]) else $error("tx slot short");
    rx_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rx_valid != 4'h0 |=> o_rx_valid == 4'h0) else $error("rx valid long");
    rx_single_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $onehot0(o_rx_valid)) else $error("rx valid lanes");
    rx_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rx_valid == 4'h0 |-> $stable(o_rx_sample)) else $error("rx sample moved");
    rx_lane_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rx_valid[0] |-> $stable(o_rx_sample[31:8])) else $error("rx lane moved");
endmodule
bind pts_slot_if pts_chk chk (.*);

/* File: test/pts_highway.sv */
`timescale 1ns/1ps
module pts_highway (
    output logic            o_bit_clk,
    output logic            o_fs,
    output logic            o_rx,
    output logic      [7:0] o_tx_byte,
    output logic            o_tx_done,
    input  wire logic       i_tx,
    input  wire logic       i_oe,
    input  wire logic [7:0] i_rx_byte
);
    logic [9:0] pc_q = 10'h3e7;
    logic [7:0] rb_q = 8'h00;
    initial begin
        o_bit_clk = 1'b0;
        forever #62.5 o_bit_clk = ~o_bit_clk;
    end
    // Strobe every 1000 bits, both lines move on the falling edge
    assign o_fs = pc_q == 10'h000;
    assign o_rx = rb_q[~pc_q[2:0]];
    always @(negedge o_bit_clk) begin
        pc_q <= (pc_q == 10'h3e7) ? 10'h000 : pc_q + 10'h001;
        if (pc_q == 10'h3e7)
            rb_q <= i_rx_byte;
        if (i_oe)
            o_tx_byte <= {o_tx_byte[6:0], i_tx};
        o_tx_done <= i_oe && pc_q[2:0] == 3'h7;
    end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import pts_pkg::*;
    localparam logic [31:0] TXS = 32'h7c09_0400;
    localparam logic [31:0] RXS = 32'h7c11_0501;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        bclk, fs, rxd, txd, oe, a_law, tdone;
    logic [3:0]  rv;
    logic [7:0]  rxb, txb;
    logic [31:0] x = 32'h908f_48fa;
    logic [31:0] tx_s, rsmp;
    logic [9:0]  eq_rx[$];
    logic [9:0]  eq_tx[$];
    int          fails = 0;
    int          compares = 0;
    pts_slot_if dut (.i_clk(i_clk), .i_rst(i_rst), .i_bit_clk(bclk), .i_frame_strobe_in(fs),
        .i_pcm_rx_data_in(rxd), .o_pcm_tx_data_out(txd), .o_pcm_tx_data_oe(oe), .i_a_law(a_law),
        .i_tx_slot(TXS), .i_rx_slot(RXS), .i_tx_sample(tx_s), .o_rx_sample(rsmp), .o_rx_valid(rv));
    pts_highway hw (.o_bit_clk(bclk), .o_fs(fs), .o_rx(rxd), .o_tx_byte(txb), .o_tx_done(tdone),
        .i_tx(txd), .i_oe(oe), .i_rx_byte(rxb));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [9:0] g, input logic [9:0] e);
        compares++;
        fails += int'(g !== e);
        if (g !== e)
            $display("FAIL %0t got %h want %h", $time, g, e);
    endtask
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic note();
        for (int c = 0; c < NUM_CH; c++) begin
            eq_tx.push_back({2'h0, tx_s[c*8+:8] ^ (a_law ? A_LAW_INVERT : 8'h00)});
            eq_rx.push_back({c[1:0], rxb ^ (a_law ? A_LAW_INVERT : 8'h00)});
        end
    endtask
    always @(posedge i_clk)
        for (int c = 0; c < NUM_CH; c++)
            if (rv[c] === 1'b1)
                cmp({c[1:0], rsmp[c*8+:8]}, eq_rx.pop_front());
    always @(posedge bclk)
        if (tdone === 1'b1)
            cmp({2'h0, txb}, eq_tx.pop_front());
    initial forever #12.5 i_clk = ~i_clk;
    // Five frames of 125 us plus margin
    initial begin
        #800_000;
        fails++;
        stop_test();
    end
    // Slot 0 and last slot 124 probe the frame edges; law alternates
    initial begin
        tx_s  = x;
        rxb   = x[15:8];
        a_law = LAW_MU;
        repeat (10) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        for (int f = 1; f <= 4; f++) begin
            note();
            @(posedge fs);
            repeat (960) @(posedge bclk);
            @(negedge i_clk);
            x     = lfsr(x);
            tx_s  = x;
            rxb   = x[31:24];
            a_law = f[0] ? LAW_A : LAW_MU;
        end
        note();
        @(posedge fs);
        repeat (4) @(posedge bclk);
        cmp(10'(eq_rx.size() + eq_tx.size()), 10'h008);
        stop_test();
    end
endmodule
